// File: include/pio_regs.svh
/*
 parallel io port block: register offsets, field masks, reset values, pin map.
 assumes one aligned 32-bit word per register, port index in address bits 6:4.
*/
`ifndef PIO_REGS_SVH
`define PIO_REGS_SVH

`define PIO_NPORTS 5
`define PIO_ADDR_W 8
`define PIO_PORT_A 3'h0
`define PIO_PORT_B 3'h1
`define PIO_PORT_C 3'h2
`define PIO_PORT_D 3'h3
`define PIO_PORT_E 3'h4

// register select within a port block, address bits 3:2
`define PIO_SEL_DATA 2'h0
`define PIO_SEL_DIR 2'h1
`define PIO_SEL_PULLUP 2'h2

// byte offsets of port b registers
`define PIO_OFS_B_DATA 8'h10
`define PIO_OFS_B_DIR 8'h14
`define PIO_OFS_B_PULLUP 8'h18

`define PIO_RST_DATA 8'h00
`define PIO_RST_DIR 8'h00
`define PIO_RST_PULLUP 8'h00

// pin population of port d; other ports carry eight pins
`define PIO_IMPL_FULL 8'hFF
`define PIO_IMPL_D 8'h7F
`define PIO_OUTONLY_D 8'h60
`define PIO_INONLY_D 8'h01

// port b pins used by peripherals
`define PIO_SCI_TX_BIT 0
`define PIO_SCI_RX_BIT 1
`define PIO_TMR1_BIT 2

`endif

// File: include/pio_pkg.sv
/*
 parallel io port block: shared types.
 assumes pio_regs.svh holds all numeric constants.
*/
package pio_pkg;
   typedef logic [7:0] pio_byte_t;
   typedef enum logic [1:0] {
      PIO_RESP_OKAY = 2'b00,
      PIO_RESP_SLVERR = 2'b10
   } pio_resp_t;
endpackage

// File: design/pio_port.sv
/*
 parallel io port block: five ports of latch, direction and pull-up registers
 behind an axi4-lite slave, with port b shared with serial unit and timer.
 assumes pins are synchronous to aclk and the pad resolves o/oe/pu.
*/
// The AXI4-Lite register port and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "pio_regs.svh"

// What this block does
// - five ports, 39 pins; two pins output only, one pin input only
// - each pin has a data bit: write sets drive value, read gives pin level or latch
// - direction bits 7:0 per port, read/write, select drive and read source
// - input pin: driver off, data read returns the pin level
// - output pin: driver on, data read returns the latch contents
// - input pin: pull-up bit 0 disables, 1 enables the internal pull-up
// - output pin: pull-up bit ignored, pull-up kept off
// - peripheral owns a shared pin while active; released pin returns to gpio
// - port b pins shared with serial unit and timer channel one, peripheral wins
module pio_port (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [4:0][7:0] pin_i,
   output logic [4:0][7:0] pin_o,
   output logic [4:0][7:0] pin_oe,
   output logic [4:0][7:0] pin_pu,
   input wire logic sci_en,
   input wire logic sci_txd,
   output logic sci_rxd,
   input wire logic tmr1_en,
   input wire logic tmr1_out,
   input wire logic tmr1_oe,
   output logic tmr1_in
);

   ////////////////////////////////////////////////////////////////////////////
   // registers
   pio_pkg::pio_byte_t data_ff [`PIO_NPORTS];
   pio_pkg::pio_byte_t dir_ff [`PIO_NPORTS];
   pio_pkg::pio_byte_t pe_ff [`PIO_NPORTS];
   pio_pkg::pio_byte_t nxt_data [`PIO_NPORTS];
   pio_pkg::pio_byte_t nxt_dir [`PIO_NPORTS];
   pio_pkg::pio_byte_t nxt_pe [`PIO_NPORTS];
   pio_pkg::pio_byte_t impl [`PIO_NPORTS];
   pio_pkg::pio_byte_t dir_eff [`PIO_NPORTS];
   pio_pkg::pio_byte_t own_b;

   logic aw_have_ff, w_have_ff, awready_ff, wready_ff, bvalid_ff;
   logic nxt_aw_have, nxt_w_have, nxt_awready, nxt_wready, nxt_bvalid;
   logic [7:0] awaddr_ff, nxt_awaddr;
   logic [7:0] wdata_ff, nxt_wdata;
   logic wstrb0_ff, nxt_wstrb0;
   logic [1:0] bresp_ff, nxt_bresp;
   logic arready_ff, rvalid_ff, nxt_arready, nxt_rvalid;
   logic [31:0] rdata_ff, nxt_rdata;
   logic [1:0] rresp_ff, nxt_rresp;
   logic wr_go;
   logic [4:0][7:0] nxt_pin_o, nxt_pin_oe, nxt_pin_pu;
   logic nxt_sci_rxd, nxt_tmr1_in;
   logic [4:0][7:0] pin_o_ff, pin_oe_ff, pin_pu_ff;
   logic sci_rxd_ff, tmr1_in_ff;

   function automatic logic mapped(input logic [7:0] a);
      mapped = (a[6:4] <= `PIO_PORT_E) && !a[7] && (a[3:2] != 2'h3);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // pin population, effective direction, peripheral ownership
   always_comb begin
      for (int p = 0; p < `PIO_NPORTS; p++) begin
         impl[p] = `PIO_IMPL_FULL;
         dir_eff[p] = dir_ff[p];
      end
      impl[`PIO_PORT_D] = `PIO_IMPL_D;
      dir_eff[`PIO_PORT_D] = ((dir_ff[`PIO_PORT_D] & ~`PIO_INONLY_D) | `PIO_OUTONLY_D)
                             & `PIO_IMPL_D;
      own_b = 8'h00;
      if (sci_en) begin
         own_b[`PIO_SCI_TX_BIT] = 1'b1;
         own_b[`PIO_SCI_RX_BIT] = 1'b1;
      end
      if (tmr1_en) begin
         own_b[`PIO_TMR1_BIT] = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pin drive
   always_comb begin
      for (int p = 0; p < `PIO_NPORTS; p++) begin
         nxt_pin_oe[p] = dir_eff[p] & impl[p];
         nxt_pin_o[p] = data_ff[p] & dir_eff[p] & impl[p];
         nxt_pin_pu[p] = pe_ff[p] & ~dir_eff[p] & impl[p];
      end
      // owned pins leave gpio control; release restores it at the next enabled clock edge, when the pin registers load
      nxt_pin_oe[`PIO_PORT_B] = nxt_pin_oe[`PIO_PORT_B] & ~own_b;
      nxt_pin_o[`PIO_PORT_B] = nxt_pin_o[`PIO_PORT_B] & ~own_b;
      nxt_pin_pu[`PIO_PORT_B] = nxt_pin_pu[`PIO_PORT_B] & ~own_b;
      if (sci_en) begin
         nxt_pin_oe[`PIO_PORT_B][`PIO_SCI_TX_BIT] = 1'b1;
         nxt_pin_o[`PIO_PORT_B][`PIO_SCI_TX_BIT] = sci_txd;
      end
      if (tmr1_en) begin
         nxt_pin_oe[`PIO_PORT_B][`PIO_TMR1_BIT] = tmr1_oe;
         nxt_pin_o[`PIO_PORT_B][`PIO_TMR1_BIT] = tmr1_out & tmr1_oe;
      end
      nxt_sci_rxd = pin_i[`PIO_PORT_B][`PIO_SCI_RX_BIT];
      nxt_tmr1_in = pin_i[`PIO_PORT_B][`PIO_TMR1_BIT];
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_o_ff <= '0;
         pin_oe_ff <= '0;
         pin_pu_ff <= '0;
         sci_rxd_ff <= 1'b0;
         tmr1_in_ff <= 1'b0;
      end else if (ce) begin
         pin_o_ff <= nxt_pin_o;
         pin_oe_ff <= nxt_pin_oe;
         pin_pu_ff <= nxt_pin_pu;
         sci_rxd_ff <= nxt_sci_rxd;
         tmr1_in_ff <= nxt_tmr1_in;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // axi4-lite write channel and register update
   assign wr_go = aw_have_ff && w_have_ff && !bvalid_ff;

   always_comb begin
      nxt_aw_have = aw_have_ff;
      nxt_w_have = w_have_ff;
      nxt_awaddr = awaddr_ff;
      nxt_wdata = wdata_ff;
      nxt_wstrb0 = wstrb0_ff;
      nxt_bvalid = bvalid_ff;
      nxt_bresp = bresp_ff;
      for (int p = 0; p < `PIO_NPORTS; p++) begin
         nxt_data[p] = data_ff[p];
         nxt_dir[p] = dir_ff[p];
         nxt_pe[p] = pe_ff[p];
      end
      if (s_axi_awvalid && awready_ff) begin
         nxt_aw_have = 1'b1;
         nxt_awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_ff) begin
         nxt_w_have = 1'b1;
         nxt_wdata = s_axi_wdata[7:0];
         nxt_wstrb0 = s_axi_wstrb[0];
      end
      if (bvalid_ff && s_axi_bready) begin
         nxt_bvalid = 1'b0;
      end
      if (wr_go) begin
         nxt_aw_have = 1'b0;
         nxt_w_have = 1'b0;
         nxt_bvalid = 1'b1;
         nxt_bresp = mapped(awaddr_ff) ? pio_pkg::PIO_RESP_OKAY : pio_pkg::PIO_RESP_SLVERR;
         if (mapped(awaddr_ff) && wstrb0_ff) begin
            case (awaddr_ff[3:2])
               `PIO_SEL_DATA: nxt_data[awaddr_ff[6:4]] = wdata_ff;
               `PIO_SEL_DIR: nxt_dir[awaddr_ff[6:4]] = wdata_ff;
               `PIO_SEL_PULLUP: nxt_pe[awaddr_ff[6:4]] = wdata_ff;
               default: nxt_bvalid = 1'b1;
            endcase
         end
      end
      nxt_awready = !nxt_aw_have && !nxt_bvalid;
      nxt_wready = !nxt_w_have && !nxt_bvalid;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_ff <= 1'b0;
         w_have_ff <= 1'b0;
         awready_ff <= 1'b0;
         wready_ff <= 1'b0;
         bvalid_ff <= 1'b0;
         bresp_ff <= pio_pkg::PIO_RESP_OKAY;
         awaddr_ff <= 8'h00;
         wdata_ff <= 8'h00;
         wstrb0_ff <= 1'b0;
         for (int p = 0; p < `PIO_NPORTS; p++) begin
            data_ff[p] <= `PIO_RST_DATA;
            dir_ff[p] <= `PIO_RST_DIR;
            pe_ff[p] <= `PIO_RST_PULLUP;
         end
      end else if (ce) begin
         aw_have_ff <= nxt_aw_have;
         w_have_ff <= nxt_w_have;
         awready_ff <= nxt_awready;
         wready_ff <= nxt_wready;
         bvalid_ff <= nxt_bvalid;
         bresp_ff <= nxt_bresp;
         awaddr_ff <= nxt_awaddr;
         wdata_ff <= nxt_wdata;
         wstrb0_ff <= nxt_wstrb0;
         for (int p = 0; p < `PIO_NPORTS; p++) begin
            data_ff[p] <= nxt_data[p];
            dir_ff[p] <= nxt_dir[p];
            pe_ff[p] <= nxt_pe[p];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // axi4-lite read channel
   always_comb begin
      nxt_rvalid = rvalid_ff;
      nxt_rdata = rdata_ff;
      nxt_rresp = rresp_ff;
      if (rvalid_ff && s_axi_rready) begin
         nxt_rvalid = 1'b0;
      end
      if (s_axi_arvalid && arready_ff) begin
         nxt_rvalid = 1'b1;
         nxt_rdata = 32'h0000_0000;
         nxt_rresp = pio_pkg::PIO_RESP_SLVERR;
         if (mapped(s_axi_araddr)) begin
            nxt_rresp = pio_pkg::PIO_RESP_OKAY;
            case (s_axi_araddr[3:2])
               `PIO_SEL_DATA: nxt_rdata[7:0] = impl[s_axi_araddr[6:4]] &
                  ((dir_eff[s_axi_araddr[6:4]] & data_ff[s_axi_araddr[6:4]]) |
                   (~dir_eff[s_axi_araddr[6:4]] & pin_i[s_axi_araddr[6:4]]));
               `PIO_SEL_DIR: nxt_rdata[7:0] = dir_ff[s_axi_araddr[6:4]];
               `PIO_SEL_PULLUP: nxt_rdata[7:0] = pe_ff[s_axi_araddr[6:4]];
               default: nxt_rdata = 32'h0000_0000;
            endcase
         end
      end
      nxt_arready = !nxt_rvalid;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_ff <= 1'b0;
         rvalid_ff <= 1'b0;
         rdata_ff <= 32'h0000_0000;
         rresp_ff <= pio_pkg::PIO_RESP_OKAY;
      end else if (ce) begin
         arready_ff <= nxt_arready;
         rvalid_ff <= nxt_rvalid;
         rdata_ff <= nxt_rdata;
         rresp_ff <= nxt_rresp;
      end
   end

   assign s_axi_awready = awready_ff;
   assign s_axi_wready = wready_ff;
   assign s_axi_bvalid = bvalid_ff;
   assign s_axi_bresp = bresp_ff;
   assign s_axi_arready = arready_ff;
   assign s_axi_rvalid = rvalid_ff;
   assign s_axi_rdata = rdata_ff;
   assign s_axi_rresp = rresp_ff;
   assign pin_o = pin_o_ff;
   assign pin_oe = pin_oe_ff;
   assign pin_pu = pin_pu_ff;
   assign sci_rxd = sci_rxd_ff;
   assign tmr1_in = tmr1_in_ff;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   property p_port_d_pins;
      ce |=> ((pin_oe[3] & `PIO_OUTONLY_D) == `PIO_OUTONLY_D)
             && ((pin_oe[3] & (`PIO_INONLY_D | ~`PIO_IMPL_D)) == 8'h00);
   endproperty
   a_port_d_pins: assert property (p_port_d_pins) else $error("port d pin kinds wrong");

   property p_data_write;
      ce && wr_go && wstrb0_ff && awaddr_ff == `PIO_OFS_B_DATA ##1 ce && !sci_en && !tmr1_en
      |=> pin_o[1] == ($past(wdata_ff, 2) & $past(dir_ff[1]));
   endproperty
   a_data_write: assert property (p_data_write) else $error("data write not driven");

   property p_dir_write;
      ce && wr_go && wstrb0_ff && awaddr_ff == `PIO_OFS_B_DIR |=> dir_ff[1] == $past(wdata_ff);
   endproperty
   a_dir_write: assert property (p_dir_write) else $error("direction write lost");

   property p_read_data;
      ce && s_axi_arvalid && arready_ff && s_axi_araddr == `PIO_OFS_B_DATA
      |=> rvalid_ff && rdata_ff == {24'h000000, (($past(dir_ff[1]) & $past(data_ff[1]))
          | (~$past(dir_ff[1]) & $past(pin_i[1])))};
   endproperty
   a_read_data: assert property (p_read_data) else $error("data read source wrong");

   property p_drive_dir;
      ce |=> ((pin_oe[1] ^ $past(dir_ff[1])) & ~$past(own_b)) == 8'h00;
   endproperty
   a_drive_dir: assert property (p_drive_dir) else $error("driver not following direction");

   property p_pullup;
      ce && !sci_en && !tmr1_en |=> pin_pu[1] == ($past(pe_ff[1]) & ~$past(dir_ff[1]));
   endproperty
   a_pullup: assert property (p_pullup) else $error("pull-up enable wrong");

   property p_pullup_off;
      (pin_pu[0] & pin_oe[0]) == 8'h00 && (pin_pu[1] & pin_oe[1]) == 8'h00
      && (pin_pu[3] & pin_oe[3]) == 8'h00;
   endproperty
   a_pullup_off: assert property (p_pullup_off) else $error("pull-up on a driven pin");

   property p_sci_own;
      ce && sci_en |=> pin_oe[1][`PIO_SCI_TX_BIT] && !pin_oe[1][`PIO_SCI_RX_BIT]
      && pin_o[1][`PIO_SCI_TX_BIT] == $past(sci_txd) && !pin_pu[1][`PIO_SCI_RX_BIT];
   endproperty
   a_sci_own: assert property (p_sci_own) else $error("serial unit lost its pins");

   property p_tmr_own;
      ce && tmr1_en |=> pin_oe[1][`PIO_TMR1_BIT] == $past(tmr1_oe)
      && !pin_pu[1][`PIO_TMR1_BIT];
   endproperty
   a_tmr_own: assert property (p_tmr_own) else $error("timer pin not owned");

   property p_reset_inputs;
      $past(!aresetn) |-> pin_oe[0] == 8'h00 && pin_oe[1] == 8'h00 && dir_ff[2] == 8'h00;
   endproperty
   a_reset_inputs: assert property (p_reset_inputs) else $error("pin driven after reset");

endmodule

// File: test/pio_board.sv
/*
 board model for the parallel io port: resolves each pin level from the
 device drive, an external driver and the internal pull-up.
 assumes the external driver yields to the device while the device drives.
*/
`timescale 1ns/1ps

module pio_board (
   input wire logic aclk,
   input wire logic [4:0][7:0] pin_o,
   input wire logic [4:0][7:0] pin_oe,
   input wire logic [4:0][7:0] pin_pu,
   input wire logic [4:0][7:0] ext_val,
   input wire logic [4:0][7:0] ext_en,
   output logic [4:0][7:0] pin_i
);
   logic tgl_ff = 1'b0;

   ////////////////////////////////////////////////////////////////////////////
   // a floating line shows a pattern that changes every cycle
   always_ff @(posedge aclk) begin
      tgl_ff <= ~tgl_ff;
   end

   always_comb begin
      for (int p = 0; p < 5; p++) begin
         for (int b = 0; b < 8; b++) begin
            if (pin_oe[p][b]) begin
               pin_i[p][b] = pin_o[p][b];
            end else if (ext_en[p][b]) begin
               pin_i[p][b] = ext_val[p][b];
            end else if (pin_pu[p][b]) begin
               pin_i[p][b] = 1'b1;
            end else begin
               pin_i[p][b] = tgl_ff ^ b[0];
            end
         end
      end
   end
endmodule

// File: test/test_parallel_io_port.sv
/*
 self-checking bench for the parallel io port: axi4-lite register access,
 pin direction, read source, pull-up and peripheral ownership of port b.
 assumes the board model in pio_board.sv and the map in pio_regs.svh.
*/
`timescale 1ns/1ps
`include "pio_regs.svh"

`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin failures++; \
   $display("FAIL %0t: got %h expected %h", $time, got, exp); end end

module test_parallel_io_port;
   logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
   logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, sci_en, sci_txd, sci_rxd, tmr1_en, tmr1_out, tmr1_oe, tmr1_in;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [4:0][7:0] pin_i, pin_o, pin_oe, pin_pu, ext_val, ext_en;
   int failures = 0;
   int total_checks = 0;
   localparam logic [1:0] OK = pio_pkg::PIO_RESP_OKAY;
   localparam logic [1:0] ERR = pio_pkg::PIO_RESP_SLVERR;

   pio_port DUT (.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe),
      .pin_pu(pin_pu), .sci_en(sci_en), .sci_txd(sci_txd), .sci_rxd(sci_rxd),
      .tmr1_en(tmr1_en), .tmr1_out(tmr1_out), .tmr1_oe(tmr1_oe), .tmr1_in(tmr1_in));

   pio_board board (.aclk(aclk), .pin_o(pin_o), .pin_oe(pin_oe), .pin_pu(pin_pu),
      .ext_val(ext_val), .ext_en(ext_en), .pin_i(pin_i));

   ////////////////////////////////////////////////////////////////////////////
   // verdict and bus tasks
   task automatic conclude();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
      int n;
      n = 0;
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= {24'h000000, d};
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1 && n < 40);
      if (s_axi_bvalid !== 1'b1) begin
         failures++;
         conclude();
      end else begin
         `CHK(s_axi_bresp, er)
      end
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] ed, input logic [1:0] er);
      int n;
      n = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1 && n < 40);
      if (s_axi_rvalid !== 1'b1) begin
         failures++;
         conclude();
      end else begin
         `CHK(s_axi_rdata, {24'h000000, ed})
         `CHK(s_axi_rresp, er)
      end
   endtask

   task automatic settle();
      repeat (3) @(posedge aclk);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // clock and main sequence
   initial begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end

   initial begin
      aresetn = 1'b0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      s_axi_awaddr = 8'h00;
      s_axi_araddr = 8'h00;
      s_axi_wdata = 32'h00000000;
      {sci_en, sci_txd, tmr1_en, tmr1_out, tmr1_oe} = '0;
      ext_val = {8'hFF, 8'hFF, 8'hFF, 8'h3E, 8'hFF};
      ext_en = {8'h00, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(`PIO_OFS_B_DIR, 8'h00, OK);
      rd(`PIO_OFS_B_PULLUP, 8'h00, OK);
      `CHK(pin_oe[1], 8'h00)
      // every port: direction readback, pull-ups on so no input floats
      for (int p = 0; p < 5; p++) begin
         wr(8'(p * 16 + 4), 8'h3C ^ 8'(p), OK);
         rd(8'(p * 16 + 4), 8'h3C ^ 8'(p), OK);
         wr(8'(p * 16 + 8), 8'hFF, OK);
         rd(8'(p * 16 + 8), 8'hFF, OK);
      end
      // port b: low nibble output, high nibble input
      wr(`PIO_OFS_B_DIR, 8'h0F, OK);
      wr(`PIO_OFS_B_DATA, 8'hA5, OK);
      settle();
      rd(`PIO_OFS_B_DATA, 8'h35, OK);
      `CHK(pin_oe[1], 8'h0F)
      `CHK(pin_o[1], 8'h05)
      `CHK(pin_pu[1], 8'hF0)
      // peripherals take bits 0..2 over the gpio setting
      sci_en <= 1'b1;
      sci_txd <= 1'b1;
      tmr1_en <= 1'b1;
      tmr1_oe <= 1'b1;
      settle();
      `CHK(pin_oe[1][2:0], 3'b101)
      `CHK(pin_o[1][2:0], 3'b001)
      `CHK(sci_rxd, 1'b1)
      `CHK(tmr1_in, 1'b0)
      sci_en <= 1'b0;
      tmr1_en <= 1'b0;
      settle();
      `CHK(pin_o[1], 8'h05)
      `CHK(pin_oe[1], 8'h0F)
      wr(`PIO_OFS_B_DIR, 8'h00, OK);
      settle();
      rd(`PIO_OFS_B_DATA, 8'h3E, OK);
      `CHK(pin_oe[1], 8'h00)
      `CHK(pin_pu[1], 8'hFF)
      // port d: absent bit 7, output-only bits 5,6, input-only bit 0
      wr(8'h34, 8'h00, OK);
      settle();
      rd(8'h30, 8'h1F, OK);
      `CHK(pin_oe[3], 8'h60)
      wr(8'h34, 8'hFF, OK);
      settle();
      `CHK(pin_oe[3], 8'h7E)
      rd(8'h30, 8'h01, OK);
      // unmapped places answer with an error and change nothing
      wr(8'h1C, 8'hFF, ERR);
      rd(8'h1C, 8'h00, ERR);
      rd(8'h50, 8'h00, ERR);
      rd(`PIO_OFS_B_PULLUP, 8'hFF, OK);
      conclude();
   end
endmodule
